// *** fcc_pkg.sv ***
package fcc_pkg;
  // ---------------------------------------------------------------
  // control register layout
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_W     = 5;
  localparam int unsigned VOLT_MSB   = 4;
  localparam int unsigned VOLT_LSB   = 3;
  localparam int unsigned CURR_MSB   = 2;
  localparam int unsigned CURR_LSB   = 0;
  localparam logic [4:0]  CTRL_RST   = 5'h18;
  localparam logic [2:0]  CURR_TOP   = 3'h5;
  // ---------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------
  localparam logic [6:0]  I2C_ADDR   = 7'h2a;
  localparam logic [3:0]  BIT_ACK    = 4'h8;
  localparam logic [3:0]  BIT_END    = 4'h9;
  // ---------------------------------------------------------------
  // boost timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned OFF_STEP_NS = 100;
  localparam int unsigned MAX_ON_NS   = 2000;
  localparam int unsigned OFF_STEP_CYC = (OFF_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAX_ON_CYC   = (MAX_ON_NS * CLK_MHZ) / 1000;
  localparam int unsigned TMR_W        = 12;
  localparam int unsigned SYNC_N       = 9;
endpackage

// *** fcc_serial_if.sv ***
`timescale 1ns/10ps
interface fcc_serial_if;
  logic       sclk;
  logic       sdi;
  logic       sel_n;
  logic       i2c_mode;
  logic       sda_oe;
  logic [4:0] ctrl;
  modport ctl  (output sclk, output sdi, output sel_n, output i2c_mode, input sda_oe, input ctrl);
  modport port (input sclk, input sdi, input sel_n, input i2c_mode, output sda_oe, output ctrl);
endinterface

// *** fcc_serial.sv ***
`timescale 1ns/10ps
module fcc_serial (
  input  wire logic   clk,
  input  wire logic   rst,
  fcc_serial_if.port  sp
);
  typedef enum logic [3:0] {
    FCC_I_IDLE = 4'b0001,
    FCC_I_ADDR = 4'b0010,
    FCC_I_WR   = 4'b0100,
    FCC_I_RD   = 4'b1000
  } fcc_i2c_st_t;

  fcc_i2c_st_t st_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;
  logic        oe_q;
  logic [4:0]  ctrl_q;
  logic [4:0]  spi_sh_q;
  logic [2:0]  spi_cnt_q;
  logic        scl_p_q;
  logic        sda_p_q;
  logic        sel_p_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start;
  logic        stop;
  logic        spi_on;
  logic        i2c_clr;
  logic [7:0]  rd_byte;

  assign scl_rise = sp.sclk & ~scl_p_q;
  assign scl_fall = ~sp.sclk & scl_p_q;
  assign start    = sp.sclk & scl_p_q & sda_p_q & ~sp.sdi;
  assign stop     = sp.sclk & scl_p_q & ~sda_p_q & sp.sdi;
  assign spi_on   = ~sp.i2c_mode & ~sp.sel_n;
  assign i2c_clr  = sp.i2c_mode & ~sp.sel_n;
  assign rd_byte  = {3'h0, ctrl_q};
  assign sp.sda_oe = oe_q;
  assign sp.ctrl   = ctrl_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b1;
      sel_p_q <= 1'b1;
    end else begin
      scl_p_q <= sp.sclk;
      sda_p_q <= sp.sdi;
      sel_p_q <= sp.sel_n;
    end
  end

  // ---------------------------------------------------------------
  // spi receive
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spi_sh_q  <= 5'h00;
      spi_cnt_q <= 3'h0;
    end else if (!spi_on) begin
      spi_cnt_q <= 3'h0;
    end else if (scl_rise) begin
      spi_sh_q <= {spi_sh_q[3:0], sp.sdi};
      if (spi_cnt_q != 3'h5) begin
        spi_cnt_q <= spi_cnt_q + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= fcc_pkg::CTRL_RST;
    end else if (i2c_clr) begin
      ctrl_q <= fcc_pkg::CTRL_RST;
    end else if (!sp.i2c_mode && sp.sel_n && !sel_p_q && spi_cnt_q == 3'h5) begin
      ctrl_q <= spi_sh_q;
    end else if (st_q == FCC_I_WR && scl_fall && bit_q == fcc_pkg::BIT_ACK) begin
      ctrl_q <= sh_q[4:0];
    end
  end

  // ---------------------------------------------------------------
  // i2c slave
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q  <= FCC_I_IDLE;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
      oe_q  <= 1'b0;
    end else if (!sp.i2c_mode || i2c_clr || stop) begin
      st_q <= FCC_I_IDLE;
      oe_q <= 1'b0;
    end else if (start) begin
      st_q  <= FCC_I_ADDR;
      bit_q <= 4'h0;
      oe_q  <= 1'b0;
    end else begin
      case (st_q)
        FCC_I_ADDR, FCC_I_WR: begin
          if (scl_rise && bit_q < fcc_pkg::BIT_ACK) begin
            sh_q  <= {sh_q[6:0], sp.sdi};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == fcc_pkg::BIT_ACK) begin
            if (st_q == FCC_I_ADDR && sh_q[7:1] != fcc_pkg::I2C_ADDR) begin
              st_q <= FCC_I_IDLE;
            end else begin
              oe_q  <= 1'b1;
              bit_q <= fcc_pkg::BIT_END;
            end
          end else if (scl_fall && bit_q == fcc_pkg::BIT_END) begin
            bit_q <= 4'h0;
            if (st_q == FCC_I_ADDR && sh_q[0]) begin
              st_q <= FCC_I_RD;
              sh_q <= rd_byte;
              oe_q <= ~rd_byte[7];
            end else begin
              st_q <= FCC_I_WR;
              oe_q <= 1'b0;
            end
          end
        end
        FCC_I_RD: begin
          if (scl_fall && bit_q < 4'h7) begin
            sh_q  <= {sh_q[6:0], 1'b0};
            oe_q  <= ~sh_q[6];
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h7) begin
            oe_q  <= 1'b0;
            bit_q <= fcc_pkg::BIT_ACK;
          end else if (scl_rise && bit_q == fcc_pkg::BIT_ACK) begin
            if (sp.sdi) begin
              st_q <= FCC_I_IDLE;
            end else begin
              bit_q <= fcc_pkg::BIT_END;
            end
          end else if (scl_fall && bit_q == fcc_pkg::BIT_END) begin
            bit_q <= 4'h0;
            sh_q  <= rd_byte;
            oe_q  <= ~rd_byte[7];
          end
        end
        FCC_I_IDLE: begin
          oe_q <= 1'b0;
        end
        default: begin
          st_q <= FCC_I_IDLE;
        end
      endcase
    end
  end
endmodule // fcc_serial

// *** fcc_top.sv ***
`timescale 1ns/10ps
// How it works
// - charge cycle starts on fill request rising edge
// - target reached: stop boost, release done
// - fill request low aborts charge, powers down
// - done open drain, low only while charging
// - target judged from synchronised feedback comparator
// - peak current and off time pace boost
// - gate drive follows flash input level
// - gate drive ends when flash falls
// - bus select high i2c, low spi
// - spi accepts data only while select low
// - select low in i2c resets port, register
// - i2c ack and read data open drain
// - torch sink follows torch enable
// - six current codes, four voltage levels
// - five-bit register: voltage 4:3, current 2:0
// - voltage field resets to highest level 11
module fcc_top #(
  parameter int unsigned OFF_STEP = fcc_pkg::OFF_STEP_CYC,
  parameter int unsigned MAX_ON   = fcc_pkg::MAX_ON_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fill_request,
  input  wire logic       feedback_sense,
  input  wire logic       peak_current_sense,
  input  wire logic       flash_in,
  input  wire logic       torch_enable,
  input  wire logic       bus_select,
  input  wire logic       serial_select_n,
  input  wire logic       serial_clk,
  input  wire logic       serial_io_pin_i,
  output logic            serial_io_pin_o,
  output logic            serial_io_pin_oe,
  output logic            done_o,
  output logic            done_oe,
  output logic            boost_switch_on,
  output logic            power_down,
  output logic            gate_drive_out,
  output logic            torch_sink_on,
  output logic [1:0]      voltage_level_field,
  output logic [2:0]      battery_current_field
);
  typedef enum logic [3:0] {
    FCC_IDLE = 4'b0001,
    FCC_ON   = 4'b0010,
    FCC_OFF  = 4'b0100,
    FCC_DONE = 4'b1000
  } fcc_chg_st_t;

  localparam int unsigned N = fcc_pkg::SYNC_N;
  localparam int unsigned W = fcc_pkg::TMR_W;

  logic [N-1:0] raw;
  logic [N-1:0] s1_q;
  logic [N-1:0] s2_q;
  logic         fill_s;
  logic         fb_s;
  logic         peak_s;
  logic         flash_s;
  logic         torch_s;
  logic         fill_p_q;
  fcc_chg_st_t  st_q;
  logic [W-1:0] tmr_q;
  logic [4:0]   ctrl;

  fcc_serial_if sif ();

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  assign raw = {serial_io_pin_i, serial_clk, serial_select_n, bus_select,
                torch_enable, flash_in, peak_current_sense, feedback_sense, fill_request};

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate

  assign fill_s  = s2_q[0];
  assign fb_s    = s2_q[1];
  assign peak_s  = s2_q[2];
  assign flash_s = s2_q[3];
  assign torch_s = s2_q[4];

  assign sif.i2c_mode = s2_q[5];
  assign sif.sel_n    = s2_q[6];
  assign sif.sclk     = s2_q[7];
  assign sif.sdi      = s2_q[8];
  assign ctrl         = sif.ctrl;

  fcc_serial u_serial (
    .clk (clk),
    .rst (rst),
    .sp  (sif)
  );

  assign serial_io_pin_o  = 1'b0;
  assign serial_io_pin_oe = sif.sda_oe;

  // ---------------------------------------------------------------
  // settings to the analog side
  // ---------------------------------------------------------------
  function automatic logic [2:0] fcc_curr_clamp(input logic [2:0] code);
    fcc_curr_clamp = (code > fcc_pkg::CURR_TOP) ? fcc_pkg::CURR_TOP : code;
  endfunction

  function automatic logic [W-1:0] fcc_off_cycles(input logic [2:0] code);
    logic [W-1:0] steps;
    steps = W'(4'h8 - {1'b0, fcc_curr_clamp(code)});
    fcc_off_cycles = W'(steps * W'(OFF_STEP));
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      voltage_level_field   <= fcc_pkg::CTRL_RST[fcc_pkg::VOLT_MSB:fcc_pkg::VOLT_LSB];
      battery_current_field <= fcc_pkg::CTRL_RST[fcc_pkg::CURR_MSB:fcc_pkg::CURR_LSB];
    end else begin
      voltage_level_field   <= ctrl[fcc_pkg::VOLT_MSB:fcc_pkg::VOLT_LSB];
      battery_current_field <= fcc_curr_clamp(ctrl[fcc_pkg::CURR_MSB:fcc_pkg::CURR_LSB]);
    end
  end

  // ---------------------------------------------------------------
  // charge cycle control
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_p_q <= 1'b0;
    end else begin
      fill_p_q <= fill_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q  <= FCC_IDLE;
      tmr_q <= '0;
    end else if (!fill_s) begin
      st_q  <= FCC_IDLE;
      tmr_q <= '0;
    end else begin
      case (st_q)
        FCC_IDLE: begin
          if (!fill_p_q) begin
            st_q  <= FCC_ON;
            tmr_q <= '0;
          end
        end
        FCC_ON: begin
          if (fb_s) begin
            st_q <= FCC_DONE;
          end else if (peak_s || tmr_q >= W'(MAX_ON - 1)) begin
            st_q  <= FCC_OFF;
            tmr_q <= fcc_off_cycles(ctrl[fcc_pkg::CURR_MSB:fcc_pkg::CURR_LSB]);
          end else begin
            tmr_q <= tmr_q + W'(1);
          end
        end
        FCC_OFF: begin
          if (fb_s) begin
            st_q <= FCC_DONE;
          end else if (tmr_q <= W'(1)) begin
            st_q  <= FCC_ON;
            tmr_q <= '0;
          end else begin
            tmr_q <= tmr_q - W'(1);
          end
        end
        FCC_DONE: begin
          st_q <= FCC_DONE;
        end
        default: begin
          st_q <= FCC_IDLE;
        end
      endcase
    end
  end

  assign boost_switch_on = (st_q == FCC_ON);
  assign power_down      = (st_q == FCC_IDLE);
  assign done_o          = 1'b0;
  assign done_oe         = (st_q == FCC_ON) || (st_q == FCC_OFF);

  // ---------------------------------------------------------------
  // gate driver and torch
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_drive_out <= 1'b0;
      torch_sink_on  <= 1'b0;
    end else begin
      gate_drive_out <= flash_s;
      torch_sink_on  <= torch_s;
    end
  end
endmodule // fcc_top

// *** fcc_chk.sv ***
`timescale 1ns/10ps
module fcc_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       fill_request,
  input wire logic       feedback_sense,
  input wire logic       flash_in,
  input wire logic       torch_enable,
  input wire logic       bus_select,
  input wire logic       serial_select_n,
  input wire logic       serial_io_pin_o,
  input wire logic       serial_io_pin_oe,
  input wire logic       done_o,
  input wire logic       done_oe,
  input wire logic       boost_switch_on,
  input wire logic       power_down,
  input wire logic       gate_drive_out,
  input wire logic       torch_sink_on,
  input wire logic [1:0] voltage_level_field,
  input wire logic [2:0] battery_current_field
);
  // ---------------------------------------------------------------
  // pin behaviour
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_gate_follows: assert property (gate_drive_out == $past(flash_in, 3))
    else $error("gate drive not following flash");
  a_torch_follows: assert property (torch_sink_on == $past(torch_enable, 3))
    else $error("torch sink not following enable");
  a_spi_no_drive: assert property ((!bus_select)[*4] |-> !serial_io_pin_oe)
    else $error("data pin driven in spi mode");
  a_i2c_sel_clear: assert property ((bus_select && !serial_select_n)[*8]
    |-> voltage_level_field == 2'h3 && battery_current_field == 3'h0)
    else $error("select low in i2c did not clear register");
  a_fill_abort: assert property ((!fill_request)[*5] |-> power_down && !done_oe)
    else $error("no power down with fill low");
  a_done_halt: assert property ((fill_request && feedback_sense)[*5]
    |-> !boost_switch_on && !done_oe)
    else $error("boost not halted at target");
  a_charge_low: assert property (boost_switch_on |-> done_oe && !power_down)
    else $error("done released while switching");
  a_pins_od: assert property (serial_io_pin_o == 1'b0 && done_o == 1'b0)
    else $error("open drain pin drives high");
  a_curr_max: assert property (battery_current_field <= 3'h5)
    else $error("current code above top");
  a_start_edge: assert property ($rose(done_oe) |-> $past(fill_request, 3))
    else $error("charge started without fill request");
  c_charge: cover property ($rose(done_oe));
  c_done: cover property ($fell(done_oe) && fill_request);
  c_ack: cover property (serial_io_pin_oe);
endmodule // fcc_chk

bind fcc_top fcc_chk u_chk (.clk(clk), .rst(rst), .fill_request(fill_request),
  .feedback_sense(feedback_sense), .flash_in(flash_in), .torch_enable(torch_enable),
  .bus_select(bus_select), .serial_select_n(serial_select_n), .serial_io_pin_o(serial_io_pin_o),
  .serial_io_pin_oe(serial_io_pin_oe), .done_o(done_o), .done_oe(done_oe),
  .boost_switch_on(boost_switch_on), .power_down(power_down), .gate_drive_out(gate_drive_out),
  .torch_sink_on(torch_sink_on), .voltage_level_field(voltage_level_field),
  .battery_current_field(battery_current_field));

// *** fcc_host.sv ***
`timescale 1ns/10ps
module fcc_host (
  output logic      sclk,
  output logic      sel_n,
  output logic      sda,
  input  wire logic sda_in
);
  // ---------------------------------------------------------------
  // serial host, 48 ns clock, still between frames
  // ---------------------------------------------------------------
  localparam time HALF = 24ns;
  initial begin
    sclk = 1'b1;
    sel_n = 1'b1;
    sda = 1'b1;
  end
  task automatic sel(input logic v);
    sel_n = v;
  endtask
  task automatic spi(input logic [4:0] d);
    sel_n = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      sclk = 1'b0;
      sda = d[i];
      #HALF sclk = 1'b1;
      #HALF;
    end
    sel_n = 1'b1;
    sda = ~sda;
  endtask
  task automatic start();
    sda = 1'b1;
    #HALF sda = 1'b0;
    #HALF sclk = 1'b0;
  endtask
  task automatic stop();
    sda = 1'b0;
    #HALF sclk = 1'b1;
    #HALF sda = 1'b1;
    #HALF;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda = b[i];
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
    sda = 1'b1;
    #HALF sclk = 1'b1;
    ack = ~sda_in;
    #HALF sclk = 1'b0;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] b);
    sda = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #HALF sclk = 1'b1;
      b[i] = sda_in;
      #HALF sclk = 1'b0;
    end
    sda = nack;
    #HALF sclk = 1'b1;
    #HALF sclk = 1'b0;
    sda = 1'b1;
  endtask
endmodule // fcc_host

// *** fcc_top_tb_top.sv ***
`timescale 1ns/10ps
module fcc_top_tb_top;
  // ---------------------------------------------------------------
  // bench
  // ---------------------------------------------------------------
  logic       clk, rst, fill_request, feedback_sense, peak_current_sense;
  logic       flash_in, torch_enable, bus_select, ack;
  logic       sclk, sel_n, h_sda, oe, sd_o, done_o, done_oe, boost, pwr_dn, gate, torch;
  logic [1:0] volt;
  logic [2:0] curr;
  logic [7:0] rd;
  wire        sda_w = oe ? 1'b0 : h_sda;
  int         n_fail, checks, n_on;
  fcc_host h (.sclk(sclk), .sel_n(sel_n), .sda(h_sda), .sda_in(sda_w));
  fcc_top #(.OFF_STEP(2), .MAX_ON(8)) DUT (.clk(clk), .rst(rst), .fill_request(fill_request),
    .feedback_sense(feedback_sense), .peak_current_sense(peak_current_sense), .flash_in(flash_in),
    .torch_enable(torch_enable), .bus_select(bus_select), .serial_select_n(sel_n),
    .serial_clk(sclk), .serial_io_pin_i(sda_w), .serial_io_pin_o(sd_o), .serial_io_pin_oe(oe),
    .done_o(done_o), .done_oe(done_oe), .boost_switch_on(boost), .power_down(pwr_dn),
    .gate_drive_out(gate), .torch_sink_on(torch), .voltage_level_field(volt),
    .battery_current_field(curr));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #50us;
    n_fail++;
    results();
  end
  initial begin
    {rst, fill_request, feedback_sense, peak_current_sense} = 4'h8;
    {flash_in, torch_enable, bus_select} = 3'h0;
    wt(2);
    rst = 1'b0;
    wt(3);
    chk(volt, 8'h03);
    chk(curr, 8'h00);
    chk(pwr_dn, 8'h01);
    chk(done_oe, 8'h00);
    $display("test reset done");
    flash_in = 1'b1;
    torch_enable = 1'b1;
    wt(4);
    chk(gate, 8'h01);
    chk(torch, 8'h01);
    flash_in = 1'b0;
    torch_enable = 1'b0;
    wt(4);
    chk(gate, 8'h00);
    chk(torch, 8'h00);
    $display("test pins done");
    h.spi(5'h0e);
    wt(20);
    chk(volt, 8'h01);
    chk(curr, 8'h05);
    $display("test spi done");
    fill_request = 1'b1;
    wt(4);
    chk(boost, 8'h01);
    chk(done_oe, 8'h01);
    chk(pwr_dn, 8'h00);
    feedback_sense = 1'b1;
    wt(4);
    chk(done_oe, 8'h00);
    chk(boost, 8'h00);
    feedback_sense = 1'b0;
    wt(6);
    chk(done_oe, 8'h00);
    fill_request = 1'b0;
    wt(4);
    chk(pwr_dn, 8'h01);
    fill_request = 1'b1;
    peak_current_sense = 1'b1;
    wt(4);
    n_on = 0;
    repeat (20) begin
      @(negedge clk);
      n_on += boost;
    end
    chk(n_on < 8, 8'h01);
    peak_current_sense = 1'b0;
    fill_request = 1'b0;
    wt(4);
    chk(pwr_dn, 8'h01);
    $display("test charge done");
    bus_select = 1'b1;
    wt(4);
    h.start();
    h.wbyte({fcc_pkg::I2C_ADDR, 1'b0}, ack);
    chk(ack, 8'h01);
    h.wbyte(8'h03, ack);
    chk(ack, 8'h01);
    h.stop();
    wt(10);
    chk(volt, 8'h00);
    chk(curr, 8'h03);
    h.start();
    h.wbyte({fcc_pkg::I2C_ADDR, 1'b1}, ack);
    chk(ack, 8'h01);
    h.rbyte(1'b1, rd);
    chk(rd, 8'h03);
    h.stop();
    wt(4);
    h.sel(1'b0);
    wt(12);
    chk(volt, 8'h03);
    chk(curr, 8'h00);
    h.sel(1'b1);
    $display("test i2c done");
    results();
  end
endmodule // fcc_top_tb_top
